// ===== hdl/rsd_pkg.sv
package rsd_pkg;

  localparam int unsigned REG_ADDR_W = 6;

  // Register offsets
  localparam logic [5:0] OFS_RX_DATA_CHAN_A       = 6'h09;
  localparam logic [5:0] OFS_RX_VALID_MASK_CHAN_A = 6'h0a;
  localparam logic [5:0] OFS_RX_DATA_CHAN_B       = 6'h0b;
  localparam logic [5:0] OFS_RX_VALID_MASK_CHAN_B = 6'h0c;
  localparam logic [5:0] OFS_TX_IRQ_ENABLE        = 6'h0d;
  localparam logic [5:0] OFS_TX_IRQ_STATUS        = 6'h0e;
  localparam logic [5:0] OFS_TX_DATA              = 6'h0f;

  // Reset values
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [3:0] RST_TX_STATUS = 4'h0;

  // Transmit condition bit positions, shared by enable and status
  localparam int unsigned TXC_EMPTY     = 0;
  localparam int unsigned TXC_DONE      = 1;
  localparam int unsigned TXC_OVERFLOW  = 2;
  localparam int unsigned TXC_UNDERFLOW = 3;
  localparam int unsigned TXC_W         = 4;

  // Bits per serial byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h1;

  localparam logic [7:0] ALL_VALID = 8'hff;

endpackage

// ===== hdl/rsd_rx_chan.sv
`timescale 1ns/1ps
// Receive deserializer for one channel: collects bits lsb first and moves
// them, with their valid mask, into the readable data and mask registers.
module rsd_rx_chan (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Bits from the correlator
  input  wire logic       bit_stb,
  input  wire logic       bit_val,
  input  wire logic       bit_ok,
  input  wire logic       eof,
  // Readable state
  output logic      [7:0] data,
  output logic      [7:0] mask,
  output logic            full,
  output logic            all_valid
);

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] mask;
    logic [7:0] sh_d;
    logic [7:0] sh_m;
    logic [3:0] cnt;
    logic       full;
  } rsd_rx_st_t;

  rsd_rx_st_t q;
  rsd_rx_st_t d;

  always_comb
  begin
    logic [7:0] sd;
    logic [7:0] sm;
    logic [3:0] n;
    sd = q.sh_d;
    sm = q.sh_m;
    n = q.cnt;
    d = q;
    d.full = 1'b0;
    if (bit_stb)
    begin
      // First bit over the air lands in bit 0
      sd[q.cnt[2:0]] = bit_val;
      sm[q.cnt[2:0]] = bit_ok;
      n = q.cnt + 4'h1;
    end
    // A partial byte is handed over on end of frame; unfilled bits stay 0
    if (n == rsd_pkg::BYTE_BITS || (eof && n != 4'h0))
    begin
      d.data = sd;
      d.mask = sm;
      d.full = 1'b1;
      sd = rsd_pkg::RST_BYTE;
      sm = rsd_pkg::RST_BYTE;
      n = 4'h0;
    end
    d.sh_d = sd;
    d.sh_m = sm;
    d.cnt = n;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign data = q.data;
  assign mask = q.mask;
  assign full = q.full;
  // The flag describes exactly the byte held, so the mask need not be read
  assign all_valid = (q.mask == rsd_pkg::ALL_VALID);

  AST_ALL_VALID: assert property (@(posedge clk) disable iff (rst)
    $changed(all_valid) |-> full && (all_valid == &mask))
    else $error("all-valid flag moved without a transfer");

  AST_BYTE_FULL: assert property (@(posedge clk) disable iff (rst)
    (bit_stb && q.cnt == 4'h7) |=> full && q.cnt == 4'h0)
    else $error("eighth bit did not fill the data register");

  AST_FIRST_BIT: assert property (@(posedge clk) disable iff (rst)
    (bit_stb && q.cnt == 4'h0 && !eof) |=> q.sh_d[0] == $past(bit_val)
      && q.sh_m[0] == $past(bit_ok))
    else $error("first received bit not in bit 0");

  AST_EOF_FULL: assert property (@(posedge clk) disable iff (rst)
    (eof && !bit_stb && q.cnt != 4'h0) |=> full
      && data == $past(q.sh_d) && mask == $past(q.sh_m))
    else $error("end of frame did not hand over partial byte");

endmodule

// ===== hdl/rsd_serdes.sv
`timescale 1ns/1ps
// Contract
// - Channel A data is read only, resets to zero, first bit in bit 0.
// - Channel A valid mask is read only and marks each valid data bit.
// - With the all-valid flag set all eight channel A bits are valid.
// - Channel B data is read only, resets to zero, first bit in bit 0.
// - Channel B valid mask is read only and marks each valid data bit.
// - With the all-valid flag set all eight channel B bits are valid.
// - Enable resets to 0; bits 3:0 gate underflow, overflow, done, empty.
// - Underflow is seen when sending with no transmit data held.
// - Overflow is seen when data is written before the last byte moved.
// - Done is raised when all data is sent and none remains.
// - Empty is raised when the data byte moves into the shift buffer.
// - Channel full is raised on each byte or end-of-frame transfer.
// - Status bits set and read regardless of the enable bits.
// - The transmit byte goes out bit 0 first through bit 7.
module rsd_serdes (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [5:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Receive channel A
  input  wire logic       rxa_bit_stb,
  input  wire logic       rxa_bit,
  input  wire logic       rxa_bit_ok,
  input  wire logic       rxa_eof,
  output logic            rxa_full,
  output logic            rxa_all_valid,
  // Receive channel B
  input  wire logic       rxb_bit_stb,
  input  wire logic       rxb_bit,
  input  wire logic       rxb_bit_ok,
  input  wire logic       rxb_eof,
  output logic            rxb_full,
  output logic            rxb_all_valid,
  // Transmit serial side
  input  wire logic       tx_enable,
  input  wire logic       tx_bit_tick,
  output logic            tx_bit,
  output logic            tx_irq
);

  typedef struct packed {
    logic [3:0] irq_en;
    logic [7:0] hold;
    logic       hold_full;
    logic [7:0] shift;
    logic [3:0] cnt;
    logic       tx_bit;
    logic [3:0] stat;
    logic [7:0] rdata;
  } rsd_top_st_t;

  rsd_top_st_t q;
  rsd_top_st_t d;

  logic [7:0] rxa_data;
  logic [7:0] rxa_mask;
  logic [7:0] rxb_data;
  logic [7:0] rxb_mask;

  rsd_rx_chan u_rx_a (
    .clk       (clk),
    .rst       (rst),
    .bit_stb   (rxa_bit_stb),
    .bit_val   (rxa_bit),
    .bit_ok    (rxa_bit_ok),
    .eof       (rxa_eof),
    .data      (rxa_data),
    .mask      (rxa_mask),
    .full      (rxa_full),
    .all_valid (rxa_all_valid)
  );

  rsd_rx_chan u_rx_b (
    .clk       (clk),
    .rst       (rst),
    .bit_stb   (rxb_bit_stb),
    .bit_val   (rxb_bit),
    .bit_ok    (rxb_bit_ok),
    .eof       (rxb_eof),
    .data      (rxb_data),
    .mask      (rxb_mask),
    .full      (rxb_full),
    .all_valid (rxb_all_valid)
  );

  always_comb
  begin
    logic [3:0] set_v;
    logic [3:0] clr_v;
    logic       loaded;
    set_v = 4'h0;
    clr_v = 4'h0;
    loaded = 1'b0;
    d = q;
    if (tx_bit_tick && tx_enable)
    begin
      if (q.cnt == 4'h0)
      begin
        if (q.hold_full)
        begin
          // Load and send bit 0 on the same tick
          d.tx_bit = q.hold[0];
          d.shift = {1'b0, q.hold[7:1]};
          d.cnt = rsd_pkg::BYTE_BITS - 4'h1;
          d.hold_full = 1'b0;
          loaded = 1'b1;
          set_v[rsd_pkg::TXC_EMPTY] = 1'b1;
        end
        else
        begin
          set_v[rsd_pkg::TXC_UNDERFLOW] = 1'b1;
        end
      end
      else
      begin
        d.tx_bit = q.shift[0];
        d.shift = {1'b0, q.shift[7:1]};
        d.cnt = q.cnt - 4'h1;
        if (q.cnt == rsd_pkg::LAST_BIT && !q.hold_full)
        begin
          set_v[rsd_pkg::TXC_DONE] = 1'b1;
        end
      end
    end
    if (reg_wr && reg_addr == rsd_pkg::OFS_TX_DATA)
    begin
      // The unsent byte is overwritten; software learns of it by the flag
      if (q.hold_full && !loaded)
      begin
        set_v[rsd_pkg::TXC_OVERFLOW] = 1'b1;
      end
      d.hold = reg_wdata;
      d.hold_full = 1'b1;
    end
    if (reg_wr && reg_addr == rsd_pkg::OFS_TX_IRQ_ENABLE)
    begin
      // Reserved upper bits are not stored and read as zero
      d.irq_en = reg_wdata[3:0];
    end
    if (reg_rd)
    begin
      if (reg_addr == rsd_pkg::OFS_TX_IRQ_STATUS)
      begin
        clr_v = q.stat;
      end
      case (reg_addr)
        rsd_pkg::OFS_RX_DATA_CHAN_A:       d.rdata = rxa_data;
        rsd_pkg::OFS_RX_VALID_MASK_CHAN_A: d.rdata = rxa_mask;
        rsd_pkg::OFS_RX_DATA_CHAN_B:       d.rdata = rxb_data;
        rsd_pkg::OFS_RX_VALID_MASK_CHAN_B: d.rdata = rxb_mask;
        rsd_pkg::OFS_TX_IRQ_ENABLE:        d.rdata = {4'h0, q.irq_en};
        rsd_pkg::OFS_TX_IRQ_STATUS:        d.rdata = {4'h0, q.stat};
        default:                           d.rdata = rsd_pkg::RST_BYTE;
      endcase
    end
    // Set wins over read clear so no event is lost
    d.stat = (q.stat & ~clr_v) | set_v;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign tx_bit = q.tx_bit;
  assign tx_irq = |(q.stat & q.irq_en);

  AST_UNDERFLOW: assert property (@(posedge clk) disable iff (rst)
    (tx_bit_tick && tx_enable && q.cnt == 4'h0 && !q.hold_full)
      |=> q.stat[3])
    else $error("underflow not flagged");

  AST_OVERFLOW: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == 6'h0f && q.hold_full
      && !(tx_bit_tick && tx_enable && q.cnt == 4'h0)) |=> q.stat[2])
    else $error("overflow not flagged");

  AST_EMPTY_LOAD: assert property (@(posedge clk) disable iff (rst)
    (tx_bit_tick && tx_enable && q.cnt == 4'h0 && q.hold_full)
      |=> q.stat[0] && q.cnt == 4'h7 && tx_bit == $past(q.hold[0]))
    else $error("byte move did not flag empty and send bit 0");

  AST_DONE: assert property (@(posedge clk) disable iff (rst)
    (tx_bit_tick && tx_enable && q.cnt == 4'h1 && !q.hold_full)
      |=> q.stat[1] && q.cnt == 4'h0)
    else $error("done not flagged after last bit");

  AST_LSB_ORDER: assert property (@(posedge clk) disable iff (rst)
    (tx_bit_tick && tx_enable && q.cnt != 4'h0)
      |=> tx_bit == $past(q.shift[0]))
    else $error("transmit bit order wrong");

  AST_EN_WRITE: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == 6'h0d) |=> q.irq_en == $past(reg_wdata[3:0]))
    else $error("enable register did not take write");

  AST_POLL: assert property (@(posedge clk) disable iff (rst)
    (q.irq_en == 4'h0 && tx_bit_tick && tx_enable && q.cnt == 4'h0
      && !q.hold_full && !reg_wr) |=> q.stat[3] && !tx_irq)
    else $error("status not set while disabled");

  AST_IRQ: assert property (@(posedge clk) disable iff (rst)
    (q.irq_en[0] && !reg_wr && tx_bit_tick && tx_enable && q.cnt == 4'h0
      && q.hold_full) |=> tx_irq)
    else $error("enabled pending condition without interrupt");

  AST_RX_READ: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == 6'h09) |=> reg_rdata == $past(rxa_data))
    else $error("channel A data read wrong");

endmodule

// ===== bench/rsd_mcu_model.sv
`timescale 1ns/1ps
// Controller side of the register port: one strobe cycle per access
module rsd_mcu_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [5:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 16'h0000;
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = (a == 6'h0d) ? {4'h0, d[3:0]} : d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    // Released lines show garbage, not the old value
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
  endtask
endmodule

// ===== bench/radio_serdes_data_path_tb_top.sv
`timescale 1ns/1ps
module radio_serdes_data_path_tb_top;
  logic       clk = 1'b0, rst = 1'b1;
  logic       tx_enable = 1'b1, tick = 1'b0;
  logic       reg_wr, reg_rd, tx_bit, tx_irq;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [1:0] stb = 2'h0, bv = 2'h0, ok = 2'h0, eof = 2'h0;
  logic [1:0] full, allv;
  int         failures = 0, n_compared = 0, cycles = 0;
  always #20 clk = ~clk;
  rsd_mcu_model mcu (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  rsd_serdes uut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rxa_bit_stb(stb[0]), .rxa_bit(bv[0]),
    .rxa_bit_ok(ok[0]), .rxa_eof(eof[0]), .rxa_full(full[0]),
    .rxa_all_valid(allv[0]), .rxb_bit_stb(stb[1]), .rxb_bit(bv[1]),
    .rxb_bit_ok(ok[1]), .rxb_eof(eof[1]), .rxb_full(full[1]),
    .rxb_all_valid(allv[1]), .tx_enable(tx_enable),
    .tx_bit_tick(tick), .tx_bit(tx_bit), .tx_irq(tx_irq));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      test_done();
    end
  end
  // Sends n bits back to back, bit 0 first, then an optional frame end
  task automatic rx(input int c, n, input logic [7:0] d, m, input logic e);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk);
      stb[c] = 1'b1;
      bv[c]  = d[i];
      ok[c]  = m[i];
    end
    @(negedge clk);
    stb[c] = 1'b0;
    bv[c]  = ~bv[c];
    eof[c] = e;
    if (e)
    begin
      @(negedge clk);
      eof[c] = 1'b0;
    end
    chk(full[c], 1'b1);
    @(negedge clk);
    chk(full[c], 1'b0);
  endtask
  task automatic tx_tick();
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
  endtask
  task automatic t_reset_values();
    for (int a = 9; a <= 13; a++)
    begin
      mcu.rd(a[5:0], v);
      chk(v, 8'h00);
    end
  endtask
  task automatic t_rx();
    rx(0, 8, 8'h96, 8'hff, 1'b0);
    chk(allv[0], 1'b1);
    mcu.wr(6'h09, 8'h00);
    mcu.rd(6'h09, v);
    chk(v, 8'h96);
    mcu.rd(6'h0a, v);
    chk(v, 8'hff);
    rx(1, 3, 8'h05, 8'h03, 1'b1);
    chk(allv[1], 1'b0);
    mcu.rd(6'h0b, v);
    chk(v, 8'h05);
    mcu.wr(6'h0c, 8'hff);
    mcu.rd(6'h0c, v);
    chk(v, 8'h03);
    mcu.rd(6'h3f, v);
    chk(v, 8'h00);
  endtask
  task automatic t_tx();
    mcu.wr(6'h0f, 8'ha5);
    for (int i = 0; i < 8; i++)
    begin
      tx_tick();
      chk(tx_bit, 8'(8'ha5 >> i) & 8'h01);
    end
    mcu.rd(6'h0e, v);
    chk(v, 8'h03);
    tx_tick();
    mcu.rd(6'h0e, v);
    chk(v, 8'h08);
    tx_enable = 1'b0;
    tx_tick();
    mcu.rd(6'h0e, v);
    chk(v, 8'h00);
    tx_enable = 1'b1;
  endtask
  task automatic t_overflow_irq();
    mcu.wr(6'h0f, 8'h11);
    mcu.wr(6'h0f, 8'h22);
    chk(tx_irq, 1'b0);
    mcu.wr(6'h0d, 8'hff);
    mcu.rd(6'h0d, v);
    chk(v, 8'h0f);
    chk(tx_irq, 1'b1);
    mcu.rd(6'h0e, v);
    chk(v, 8'h04);
    chk(tx_irq, 1'b0);
    tx_tick();
    chk(tx_bit, 1'b0);
    chk(tx_irq, 1'b1);
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_reset_values();
    t_rx();
    t_tx();
    t_overflow_irq();
    test_done();
  end
endmodule
